//--- core/asd_decoder.sv
// Address space decoder: register file, program memory, info overlay.
// Assumes requests and control page read data come from mclk logic.
`timescale 1ns/1ps
module asd_decoder
#(
	parameter int RAM_BYTES   = asd_pkg::RF_RAM_DEF,
	parameter int FLASH_BYTES = asd_pkg::PM_FLASH_DEF
)
(
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic               ce,
	input  wire asd_pkg::asd_rf_req_t rf_req,
	input  wire logic [7:0]         ctrl_rdata,
	input  wire asd_pkg::asd_pm_req_t pm_req,
	input  wire logic [7:0]         flash_rdata,
	input  wire logic               dm_rd,
	input  wire logic               dm_wr,
	input  wire logic               fps_wr,
	input  wire logic [7:0]         fps_wdata,
	output asd_pkg::asd_rsp_t       rf_rsp_ff,
	output logic                    ctrl_rd_ff,
	output logic                    ctrl_wr_ff,
	output logic [7:0]              ctrl_addr_ff,
	output logic [7:0]              ctrl_wdata_ff,
	output asd_pkg::asd_rsp_t       pm_rsp_ff,
	output logic                    flash_wr_ff,
	output logic [15:0]             flash_addr_ff,
	output logic [7:0]              flash_wdata_ff,
	output asd_pkg::asd_pm_region_t pm_region_ff,
	output logic                    info_en_ff,
	output asd_pkg::asd_rsp_t       dm_rsp_ff
);
	import asd_pkg::*;

	localparam int RAM_AW = $clog2(RAM_BYTES);

	////////////////////////////////////////////////////////////////////
	// Decode functions

	function automatic asd_rf_region_t rf_region(input logic [11:0] a);
		if (a >= RF_CTRL_BASE)
			rf_region = ASD_RF_CTRL;
		else if (32'(a) < RAM_BYTES)
			rf_region = ASD_RF_RAM;
		else
			rf_region = ASD_RF_HOLE;
	endfunction

	function automatic asd_pm_region_t pm_region(input logic [15:0] a,
		input logic info);
		if (info && a >= INFO_BASE && a <= INFO_LAST)
			pm_region = ASD_PM_INFO;
		else if (32'(a) >= FLASH_BYTES)
			pm_region = ASD_PM_NONE;
		else if (a < PM_RST_VEC)
			pm_region = ASD_PM_OPTION;
		else if (a < PM_ILL_TRAP)
			pm_region = ASD_PM_VECTOR;
		else if (a < PM_IRQ_BASE)
			pm_region = ASD_PM_TRAP;
		else if (a <= PM_IRQ_LAST)
			pm_region = ASD_PM_IRQ;
		else if (a <= PM_OSC_LAST)
			pm_region = ASD_PM_OSC;
		else
			pm_region = ASD_PM_CODE;
	endfunction

	// regions that may take a flash write
	function automatic logic pm_writable(input asd_pm_region_t r);
		case (r)
			ASD_PM_INFO: pm_writable = 1'b0;
			ASD_PM_NONE: pm_writable = 1'b0;
			default:     pm_writable = 1'b1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Register file path

	asd_rf_region_t rf_reg;
	logic [7:0]     ram_rdata;
	logic           ram_we;
	logic           nxt_ctrl_rd;
	logic           nxt_ctrl_wr;
	logic [7:0]     nxt_rf_rdata;

	assign rf_reg = rf_region(rf_req.addr);

	assign ram_we = rf_req.wr && rf_reg == ASD_RF_RAM;

	assign nxt_ctrl_rd = rf_req.rd && rf_reg == ASD_RF_CTRL;
	assign nxt_ctrl_wr = rf_req.wr && rf_reg == ASD_RF_CTRL;

	// Only the low address bits reach the array; the hole never writes
	asd_ram
	#(
		.DEPTH (RAM_BYTES),
		.AW    (RAM_AW)
	)
	asd_ram_i
	(
		.mclk    (mclk),
		.reset_n (reset_n),
		.ce      (ce),
		.we      (ram_we),
		.addr    (rf_req.addr[RAM_AW-1:0]),
		.wdata   (rf_req.wdata),
		.rdata   (ram_rdata)
	);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_rd_ff <= 1'b0;
			ctrl_wr_ff <= 1'b0;
		end
		else if (ce)
		begin
			ctrl_rd_ff <= nxt_ctrl_rd;
			ctrl_wr_ff <= nxt_ctrl_wr;
		end
	end

	// Address and data follow every request; only the strobes qualify them
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_addr_ff  <= 8'h00;
			ctrl_wdata_ff <= 8'h00;
		end
		else if (ce)
		begin
			ctrl_addr_ff  <= rf_req.addr[7:0];
			ctrl_wdata_ff <= rf_req.wdata;
		end
	end

	// Read data picked by region ahead of the register
	always_comb
	begin
		case (rf_reg)
			ASD_RF_RAM:
				nxt_rf_rdata = ram_rdata;
			ASD_RF_CTRL:
				nxt_rf_rdata = ctrl_rdata;
			default:
				nxt_rf_rdata = PM_BLANK;
		endcase
	end

	// Read answer one cycle after the request
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rf_rsp_ff <= '0;
		else if (ce)
		begin
			rf_rsp_ff.valid <= rf_req.rd;
			rf_rsp_ff.rdata <= nxt_rf_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Flash page select bit 7

	logic nxt_info_en;

	always_comb
	begin
		nxt_info_en = info_en_ff;
		if (fps_wr)
			nxt_info_en = fps_wdata[INFO_BIT];
	end

	// Registered so the overlay switches on a clean edge, never mid-cycle
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			info_en_ff <= FPS_RESET[INFO_BIT];
		else if (ce)
			info_en_ff <= nxt_info_en;
	end

	////////////////////////////////////////////////////////////////////
	// Program memory path

	asd_pm_region_t pm_reg;
	logic [7:0]     info_rdata;
	logic [6:0]     info_addr;
	logic [7:0]     nxt_pm_rdata;
	logic           nxt_flash_wr;

	assign pm_reg    = pm_region(pm_req.addr, info_en_ff);
	assign info_addr = 7'(pm_req.addr - INFO_BASE);

	asd_info asd_info_i
	(
		.addr  (info_addr),
		.rdata (info_rdata)
	);

	// Overlay wins over flash; unbacked addresses read FFH
	always_comb
	begin
		case (pm_reg)
			ASD_PM_INFO: nxt_pm_rdata = info_rdata;
			ASD_PM_NONE: nxt_pm_rdata = PM_BLANK;
			default:     nxt_pm_rdata = flash_rdata;
		endcase
	end

	// Read answer one cycle after the request
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			pm_rsp_ff <= '0;
		else if (ce)
		begin
			pm_rsp_ff.valid <= pm_req.rd;
			pm_rsp_ff.rdata <= nxt_pm_rdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			pm_region_ff <= ASD_PM_NONE;
		else if (ce)
			pm_region_ff <= pm_reg;
	end

	assign nxt_flash_wr = pm_req.wr && pm_writable(pm_reg);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			flash_wr_ff <= 1'b0;
		else if (ce)
			flash_wr_ff <= nxt_flash_wr;
	end

	// Address and data are only meaningful with the write strobe
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			flash_addr_ff  <= 16'h0000;
			flash_wdata_ff <= 8'h00;
		end
		else if (ce)
		begin
			flash_addr_ff  <= pm_req.addr;
			flash_wdata_ff <= pm_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data memory

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			dm_rsp_ff <= '0;
		else if (ce)
		begin
			dm_rsp_ff.valid <= dm_rd;
			dm_rsp_ff.rdata <= dm_wr ? PM_BLANK : PM_BLANK;
		end
	end
endmodule

//--- core/asd_info.sv
// Read-only information area, contents fixed at build time.
// Assumes the caller offsets the address into the 128-byte area.
`timescale 1ns/1ps
module asd_info
#(
	parameter logic [1023:0] OPT_BITS = '1,
	parameter logic [159:0]  PART_ID  = {20{8'h0F}},
	parameter logic [255:0]  CAL_DATA = '1
)
(
	input  wire logic [6:0] addr,
	output logic      [7:0] rdata
);
	import asd_pkg::*;

	// Only a read path exists; nothing here can be written
	always_comb
	begin
		if (addr < INFO_PART_LO)
			rdata = OPT_BITS[8*addr +: 8];
		else if (addr < INFO_RSV_LO)
			rdata = PART_ID[159 - 8*(addr - INFO_PART_LO) -: 8];
		else if (addr < INFO_CAL_LO)
			rdata = PM_BLANK;
		else
			rdata = CAL_DATA[8*(addr - INFO_CAL_LO) +: 8];
	end
endmodule

//--- core/asd_pkg.sv
// Address space decoder package: map constants and access carriers.
// Assumes one core clock; all addresses are byte addresses.
package asd_pkg;

	localparam int RF_AW = 12;
	localparam int PM_AW = 16;
	localparam int DW    = 8;

	localparam logic [11:0] RF_RAM_BASE  = 12'h000;
	localparam logic [11:0] RF_CTRL_BASE = 12'hF00;
	localparam logic [11:0] RF_CTRL_LAST = 12'hFFF;
	localparam int          RF_RAM_DEF   = 1024;

	localparam int          PM_FLASH_DEF = 4096;
	localparam logic [7:0]  PM_BLANK     = 8'hFF;

	localparam logic [15:0] PM_OPT_BASE  = 16'h0000;
	localparam logic [15:0] PM_RST_VEC   = 16'h0002;
	localparam logic [15:0] PM_WDT_VEC   = 16'h0004;
	localparam logic [15:0] PM_ILL_TRAP  = 16'h0006;
	localparam logic [15:0] PM_IRQ_BASE  = 16'h0008;
	localparam logic [15:0] PM_IRQ_LAST  = 16'h0037;
	localparam logic [15:0] PM_OSC_BASE  = 16'h0038;
	localparam logic [15:0] PM_OSC_LAST  = 16'h003D;
	localparam logic [15:0] PM_CODE_BASE = 16'h003E;

	localparam int          INFO_BIT     = 7;
	localparam int          INFO_SIZE    = 128;
	localparam logic [15:0] INFO_BASE    = 16'hFE00;
	localparam logic [15:0] INFO_LAST    = 16'hFF7F;
	localparam logic [6:0]  INFO_OPT_LO  = 7'h00;
	localparam logic [6:0]  INFO_PART_LO = 7'h40;
	localparam logic [6:0]  INFO_RSV_LO  = 7'h54;
	localparam logic [6:0]  INFO_CAL_LO  = 7'h60;
	localparam logic [7:0]  INFO_PAD     = 8'h0F;
	localparam logic [7:0]  FPS_RESET    = 8'h00;

	typedef enum logic [2:0] {
		ASD_PM_OPTION = 3'h0,
		ASD_PM_VECTOR = 3'h1,
		ASD_PM_TRAP   = 3'h3,
		ASD_PM_IRQ    = 3'h2,
		ASD_PM_OSC    = 3'h6,
		ASD_PM_CODE   = 3'h7,
		ASD_PM_INFO   = 3'h5,
		ASD_PM_NONE   = 3'h4
	} asd_pm_region_t;

	typedef enum logic [1:0] {
		ASD_RF_RAM  = 2'h0,
		ASD_RF_HOLE = 2'h1,
		ASD_RF_CTRL = 2'h3
	} asd_rf_region_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} asd_rf_req_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} asd_pm_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  rdata;
	} asd_rsp_t;

endpackage

//--- core/asd_ram.sv
// General-purpose RAM of the register file, flip-flop storage.
// Assumes the decoder gates writes to in-range addresses only.
`timescale 1ns/1ps
module asd_ram
#(
	parameter int DEPTH = 1024,
	parameter int AW    = 10
)
(
	input  wire logic          mclk,
	input  wire logic          reset_n,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);
	import asd_pkg::*;

	logic [7:0] mem_ff [DEPTH];

	// Contents are undefined after reset, as real RAM would be
	always_ff @(posedge mclk)
	begin
		if (ce && we)
			mem_ff[addr] <= wdata;
	end

	assign rdata = mem_ff[addr];
endmodule

//--- testbench/asd_decoder_props.sv
// Port checker of the address space decoder.
// Assumes one mclk domain and requests taken on ce edges.
`timescale 1ns/1ps
module asd_decoder_props
#(
	parameter int FLASH_BYTES = 4096
)
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	input wire asd_pkg::asd_rf_req_t rf_req,
	input wire logic [7:0] ctrl_rdata,
	input wire asd_pkg::asd_pm_req_t pm_req,
	input wire logic dm_rd,
	input wire logic fps_wr,
	input wire logic [7:0] fps_wdata,
	input wire asd_pkg::asd_rsp_t rf_rsp_ff,
	input wire logic ctrl_rd_ff,
	input wire asd_pkg::asd_rsp_t pm_rsp_ff,
	input wire logic flash_wr_ff,
	input wire logic info_en_ff,
	input wire asd_pkg::asd_rsp_t dm_rsp_ff
);
	import asd_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_rfv; ce && rf_req.rd |=> rf_rsp_ff.valid; endproperty
	a_rfv: assert property (p_rfv)
		else $error("rf read unanswered");
	property p_ctl;
		ce && rf_req.rd |=> ctrl_rd_ff == ($past(rf_req.addr) >= RF_CTRL_BASE);
	endproperty
	a_ctl: assert property (p_ctl)
		else $error("control strobe wrong");
	property p_cdat;
		ce && rf_req.rd && rf_req.addr >= RF_CTRL_BASE
			|=> rf_rsp_ff.rdata == $past(ctrl_rdata);
	endproperty
	a_cdat: assert property (p_cdat)
		else $error("control data wrong");
	property p_blank;
		ce && pm_req.rd && pm_req.addr >= FLASH_BYTES && !info_en_ff
			|=> pm_rsp_ff.rdata == PM_BLANK;
	endproperty
	a_blank: assert property (p_blank)
		else $error("blank read wrong");
	property p_fwr;
		ce && pm_req.wr |=> flash_wr_ff == ($past(pm_req.addr) < FLASH_BYTES);
	endproperty
	a_fwr: assert property (p_fwr)
		else $error("flash write gate wrong");
	property p_info; ce && fps_wr |=> info_en_ff == $past(fps_wdata[7]);
	endproperty
	a_info: assert property (p_info)
		else $error("info enable wrong");
	property p_hold; ce && !fps_wr |=> $stable(info_en_ff); endproperty
	a_hold: assert property (p_hold)
		else $error("info enable moved");
	property p_dm;
		ce && dm_rd |=> dm_rsp_ff.valid && dm_rsp_ff.rdata == PM_BLANK;
	endproperty
	a_dm: assert property (p_dm)
		else $error("data space answer wrong");
	property p_pmv; ce && pm_req.rd |=> pm_rsp_ff.valid; endproperty
	a_pmv: assert property (p_pmv)
		else $error("pm read unanswered");
endmodule
////////////////////////////////////////////////////////////////////////
bind asd_decoder asd_decoder_props #(.FLASH_BYTES(FLASH_BYTES))
	asd_decoder_props_i (.mclk, .reset_n, .ce, .rf_req, .ctrl_rdata,
	.pm_req, .dm_rd, .fps_wr, .fps_wdata, .rf_rsp_ff, .ctrl_rd_ff,
	.pm_rsp_ff, .flash_wr_ff, .info_en_ff, .dm_rsp_ff);

//--- testbench/asd_mem_model.sv
// Flash array and control page stand-ins facing the decoder.
// Assumes reads are combinational from the address of the cycle.
`timescale 1ns/1ps
module asd_mem_model
(
	input  wire logic [15:0] pm_addr,
	input  wire logic [11:0] rf_addr,
	output logic      [7:0]  flash_rdata,
	output logic      [7:0]  ctrl_rdata
);
	// Bytes change with the address, so a stale value shows
	assign flash_rdata = pm_addr[7:0] ^ pm_addr[15:8] ^ 8'h5A;
	assign ctrl_rdata  = rf_addr[7:0] ^ 8'hA5;
endmodule

//--- testbench/test_asd_decoder.sv
// Self-checking bench of the address space decoder.
// Assumes default map sizes and default info contents.
`timescale 1ns/1ps
module test_asd_decoder;
	import asd_pkg::*;
	logic mclk, reset_n, ce, dm_rd, dm_wr, fps_wr;
	logic [7:0] ctrl_rdata, flash_rdata, fps_wdata;
	logic ctrl_rd_ff, ctrl_wr_ff, flash_wr_ff, info_en_ff;
	logic [7:0] ctrl_addr_ff, ctrl_wdata_ff, flash_wdata_ff;
	logic [15:0] flash_addr_ff;
	asd_rf_req_t rf_req;
	asd_pm_req_t pm_req;
	asd_rsp_t rf_rsp_ff, pm_rsp_ff, dm_rsp_ff;
	asd_pm_region_t pm_region_ff;
	int n_mismatch, n_compared;
	asd_decoder asd_decoder_i (.mclk, .reset_n, .ce, .rf_req, .ctrl_rdata,
		.pm_req, .flash_rdata, .dm_rd, .dm_wr, .fps_wr, .fps_wdata,
		.rf_rsp_ff, .ctrl_rd_ff, .ctrl_wr_ff, .ctrl_addr_ff, .ctrl_wdata_ff,
		.pm_rsp_ff, .flash_wr_ff, .flash_addr_ff, .flash_wdata_ff,
		.pm_region_ff, .info_en_ff, .dm_rsp_ff);
	asd_mem_model asd_mem_model_i (.pm_addr(pm_req.addr),
		.rf_addr(rf_req.addr), .flash_rdata, .ctrl_rdata);
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] fpat(logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	// Requests held for one edge; cleared only by quiet
	task automatic rf(logic rd, logic wr, logic [11:0] a, logic [7:0] d);
		rf_req = '{rd, wr, a, d};
		@(negedge mclk);
	endtask
	task automatic pm(logic rd, logic wr, logic [15:0] a, logic [7:0] d);
		pm_req = '{rd, wr, a, d};
		@(negedge mclk);
	endtask
	task automatic quiet;
		rf_req = '0;
		pm_req = '0;
		@(negedge mclk);
	endtask
	task automatic pmr(logic [15:0] a, asd_pm_region_t r);
		pm(1'b1, 1'b0, a, 8'h00);
		chk("pm valid", pm_rsp_ff.valid, 1'b1);
		chk("pm data", pm_rsp_ff.rdata, a < 16'h1000 ? fpat(a) : PM_BLANK);
		chk("region", pm_region_ff, r);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_ram;
		rf(1'b0, 1'b1, 12'h000, 8'h3C);
		rf(1'b0, 1'b1, 12'h3FF, 8'hC3);
		rf(1'b0, 1'b1, 12'h400, 8'h11);
		rf(1'b1, 1'b0, 12'h000, 8'h00);
		chk("ram 000", rf_rsp_ff.rdata, 8'h3C);
		rf(1'b1, 1'b0, 12'h3FF, 8'h00);
		chk("ram 3FF", rf_rsp_ff.rdata, 8'hC3);
		rf(1'b1, 1'b0, 12'h400, 8'h00);
		chk("hole", rf_rsp_ff.rdata, 8'hFF);
		chk("no ctrl", ctrl_rd_ff, 1'b0);
		quiet;
	endtask
	task automatic t_ctrl;
		rf(1'b1, 1'b0, 12'hF10, 8'h00);
		chk("ctrl rd", ctrl_rd_ff, 1'b1);
		chk("rsvd", rf_rsp_ff.rdata, 8'hB5);
		rf(1'b1, 1'b0, 12'hFFF, 8'h00);
		chk("ctrl FFF", rf_rsp_ff.rdata, 8'h5A);
		chk("ctrl adr", ctrl_addr_ff, 8'hFF);
		rf(1'b0, 1'b1, 12'hF40, 8'h96);
		chk("ctrl wr", ctrl_wr_ff, 1'b1);
		chk("ctrl wd", ctrl_wdata_ff, 8'h96);
		quiet;
	endtask
	task automatic t_pm;
		pmr(16'h0001, ASD_PM_OPTION);
		pmr(16'h0003, ASD_PM_VECTOR);
		pmr(16'h0007, ASD_PM_TRAP);
		pmr(16'h0037, ASD_PM_IRQ);
		pmr(16'h0038, ASD_PM_OSC);
		pmr(16'h003E, ASD_PM_CODE);
		pmr(16'h0FFF, ASD_PM_CODE);
		pmr(16'hFE40, ASD_PM_NONE);
		pm(1'b0, 1'b1, 16'h0100, 8'h77);
		chk("fwr", flash_wr_ff, 1'b1);
		chk("fadr", flash_addr_ff, 16'h0100);
		chk("fwd", flash_wdata_ff, 8'h77);
		pm(1'b0, 1'b1, 16'h1000, 8'h77);
		chk("fwr out", flash_wr_ff, 1'b0);
		quiet;
	endtask
	task automatic fps(logic [7:0] d);
		fps_wr = 1'b1;
		fps_wdata = d;
		@(negedge mclk);
		fps_wr = 1'b0;
	endtask
	task automatic t_info;
		fps(8'h80);
		chk("info on", info_en_ff, 1'b1);
		pm(1'b1, 1'b0, 16'hFE53, 8'h00);
		chk("part", pm_rsp_ff.rdata, INFO_PAD);
		chk("reg info", pm_region_ff, ASD_PM_INFO);
		pm(1'b1, 1'b0, 16'hFF80, 8'h00);
		chk("past top", pm_region_ff, ASD_PM_NONE);
		pm(1'b1, 1'b0, 16'hFF7F, 8'h00);
		chk("top info", pm_region_ff, ASD_PM_INFO);
		pm(1'b1, 1'b0, 16'hFE00, 8'h00);
		chk("base info", pm_region_ff, ASD_PM_INFO);
		pm(1'b0, 1'b1, 16'hFE40, 8'h00);
		chk("no iwr", flash_wr_ff, 1'b0);
		chk("iwr reg", pm_region_ff, ASD_PM_INFO);
		quiet;
		fps(8'h7F);
		pm(1'b1, 1'b0, 16'hFE40, 8'h00);
		chk("restored", pm_rsp_ff.rdata, PM_BLANK);
		chk("info off", info_en_ff, 1'b0);
		quiet;
	endtask
	task automatic t_dm;
		dm_rd = 1'b1;
		dm_wr = 1'b1;
		@(negedge mclk);
		chk("dm valid", dm_rsp_ff.valid, 1'b1);
		chk("dm data", dm_rsp_ff.rdata, PM_BLANK);
		dm_rd = 1'b0;
		dm_wr = 1'b0;
		ce = 1'b0;
		rf(1'b1, 1'b0, 12'h000, 8'h00);
		chk("frozen", rf_rsp_ff.valid, 1'b0);
		ce = 1'b1;
		quiet;
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		{ce, reset_n, dm_rd, dm_wr, fps_wr, fps_wdata} = 13'h1000;
		rf_req = '0;
		pm_req = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (3) @(negedge mclk);
		reset_n = 1'b1;
		t_ram;
		t_ctrl;
		t_pm;
		t_info;
		t_dm;
		report_and_stop;
	end
	// A hang counts as a mismatch
	initial
	begin
		repeat (2000) @(posedge mclk);
		n_mismatch++;
		report_and_stop;
	end
endmodule
